// ==== pdt_defines.vh ====
// Constants for the programmable tile datapath
`ifndef PDT_DEFINES_VH
`define PDT_DEFINES_VH

// ************************************************
// Register offsets (byte addresses)
// ************************************************
`define PDT_O_CTRL 8'h00
`define PDT_O_STAT 8'h04
`define PDT_O_STKM 8'h08
`define PDT_O_CFG  8'h0C
`define PDT_O_OSEL 8'h10
`define PDT_O_POLY 8'h14
`define PDT_O_MASK 8'h18
`define PDT_O_REGS 8'h1C
`define PDT_O_F0   8'h20
`define PDT_O_F1   8'h24
`define PDT_O_FST  8'h28
`define PDT_O_IST  8'h2C
`define PDT_O_IMSK 8'h30
`define PDT_O_LAST 8'h30
`define PDT_CRAM_HI 3'h2

// ************************************************
// Static configuration fields
// ************************************************
`define PDT_C_MSB  2:0
`define PDT_C_SIS  4:3
`define PDT_C_DIR  6:5
`define PDT_C_CP0  8:7
`define PDT_C_CP1  10:9
`define PDT_C_CHN  11
`define PDT_M_C0   7:0
`define PDT_M_C1   15:8
`define PDT_M_OR   23:16

// ************************************************
// Per-cycle operation word fields
// ************************************************
`define PDT_W_FUNC 2:0
`define PDT_W_SRCA 4:3
`define PDT_W_SRCB 6:5
`define PDT_W_SHF  8:7
`define PDT_W_DST  10:9
`define PDT_W_CIN  12:11
`define PDT_W_CRC  13
`define PDT_W_FLD  14
`define PDT_W_FST  15

// ************************************************
// Reset values, sizes and answers
// ************************************************
`define PDT_RST_CFG  32'h00000007
`define PDT_RST_ZERO 32'h00000000
`define PDT_FDEPTH   3'h4
`define PDT_RESP_OK  2'h0
`define PDT_RESP_ERR 2'h2

`endif

// ==== pdt_datapath.v ====
// Programmable tile datapath with AXI4-Lite register slave
// How it works
// - Shift left, shift right, nibble swap and OR mask follow any ALU op
// - Two masked comparators pick operands from A0, A1, D0, D1 pairings
// - Zero, all-ones and overflow conditions; selected conditions drive fabric
// - Carry, shift data and compare pass to and from neighbour datapaths
// - Programmable MSB sets arithmetic and shift width, with output masking
// - One CRC or pseudo-random step per cycle, any polynomial
// - Two four-byte FIFOs, each set as bus-to-datapath or datapath-to-bus
// - FIFO empty and full flags are selectable fabric outputs
// - Carry and shift-out are registered and selectable on later cycles
// - Six fabric inputs choose each cycle's operation and give serial data
// - Each of six fabric outputs picks a condition or serial output
// - Bus-written control register bits drive the fabric
// - Read-only status register shows fabric signals live on read
// - Status bits may latch events until a read clears them
// - Every control and status bit has its own fabric connection
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "pdt_defines.vh"

module pdt_datapath (
	// Clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// AXI4-Lite write
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output wire [1:0]  s_axi_bresp,
	output wire        s_axi_bvalid,
	input  wire        s_axi_bready,
	// AXI4-Lite read
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0]  s_axi_rresp,
	output wire        s_axi_rvalid,
	input  wire        s_axi_rready,
	// Fabric
	input  wire [5:0]  fab_in,
	input  wire [7:0]  status_in,
	output wire [5:0]  fab_out,
	output wire [7:0]  ctl_out,
	// Neighbour chain
	input  wire        chain_ci,
	input  wire        chain_si,
	input  wire        chain_ce_in,
	output wire        chain_co,
	output wire        chain_so,
	output wire        chain_ce_out,
	// Interrupt
	output wire        irq
);

// ************************************************
// Functions
// ************************************************
function [7:0] pdt_msk;
	input [2:0] m;
	begin
		pdt_msk = 8'hFF >> (3'h7 - m);
	end
endfunction

function [7:0] pdt_sel;
	input [7:0] r0;
	input [7:0] r1;
	input [7:0] r2;
	input [7:0] r3;
	input [1:0] s;
	begin
		case (s)
		2'h0: pdt_sel = r0;
		2'h1: pdt_sel = r1;
		2'h2: pdt_sel = r2;
		default: pdt_sel = r3;
		endcase
	end
endfunction

function [31:0] pdt_merge;
	input [31:0] o;
	input [31:0] n;
	input [3:0]  s;
	integer k;
	begin
		for (k = 0; k < 4; k = k + 1) begin
			pdt_merge[8*k+:8] = s[k] ? n[8*k+:8] : o[8*k+:8];
		end
	end
endfunction

function pdt_hit;
	input [7:0] a;
	begin
		pdt_hit = (a[1:0] == 2'h0) &&
			((a <= `PDT_O_LAST) || (a[7:5] == `PDT_CRAM_HI));
	end
endfunction

// ************************************************
// State
// ************************************************
reg [7:0]  ctrl_reg;
reg [7:0]  stkm_reg;
reg [7:0]  stk_reg;
reg [31:0] cfg_reg;
reg [31:0] osel_reg;
reg [7:0]  poly_reg;
reg [31:0] mask_reg;
reg [7:0]  a0_reg;
reg [7:0]  a1_reg;
reg [7:0]  d0_reg;
reg [7:0]  d1_reg;
reg        creg_reg;
reg        sreg_reg;
reg [15:0] cram [0:7];
reg [7:0]  fmem [0:7];
reg [3:0]  frp_reg;
reg [5:0]  fcnt_reg;
reg [2:0]  ist_reg;
reg [2:0]  imsk_reg;
reg [1:0]  fe;
reg [1:0]  ff;
reg        irq_reg;
reg [5:0]  fab_out_reg;
reg        chain_co_reg;
reg        chain_so_reg;
reg        chain_ce_reg;
reg        awrdy_reg;
reg        wrdy_reg;
reg        awh_reg;
reg        wh_reg;
reg [7:0]  awq_reg;
reg [31:0] wdq_reg;
reg [3:0]  wsq_reg;
reg        bvalid_reg;
reg [1:0]  bresp_reg;
reg        arrdy_reg;
reg        rvalid_reg;
reg [31:0] rdata_reg;
reg [1:0]  rresp_reg;
integer    i;
integer    j;
integer    k;

// Register read view, used for reads and byte-lane merges
function [31:0] pdt_rmux;
	input [7:0] a;
	begin
		pdt_rmux = `PDT_RST_ZERO;
		if (a[7:5] == `PDT_CRAM_HI)
			pdt_rmux[15:0] = cram[a[4:2]];
		else begin
			case (a)
			`PDT_O_CTRL: pdt_rmux[7:0] = ctrl_reg;
			`PDT_O_STAT: pdt_rmux[7:0] =
				(stk_reg & stkm_reg) | (status_in & ~stkm_reg);
			`PDT_O_STKM: pdt_rmux[7:0] = stkm_reg;
			`PDT_O_CFG:  pdt_rmux = cfg_reg;
			`PDT_O_OSEL: pdt_rmux = osel_reg;
			`PDT_O_POLY: pdt_rmux[7:0] = poly_reg;
			`PDT_O_MASK: pdt_rmux = mask_reg;
			`PDT_O_REGS: pdt_rmux = {d1_reg, d0_reg, a1_reg, a0_reg};
			`PDT_O_F0:   pdt_rmux[7:0] = fmem[{1'b0, frp_reg[1:0]}];
			`PDT_O_F1:   pdt_rmux[7:0] = fmem[{1'b1, frp_reg[3:2]}];
			`PDT_O_FST:  pdt_rmux[7:0] = {4'h0, ff, fe};
			`PDT_O_IST:  pdt_rmux[2:0] = ist_reg;
			`PDT_O_IMSK: pdt_rmux[2:0] = imsk_reg;
			default:     pdt_rmux = `PDT_RST_ZERO;
			endcase
		end
	end
endfunction

// ************************************************
// ALU, shifter and CRC
// ************************************************
reg [15:0] cw;
reg [2:0]  m;
reg [7:0]  mm;
reg [7:0]  opa;
reg [7:0]  opb;
reg [7:0]  bx;
reg        cin;
reg        si;
reg [8:0]  sum;
reg [7:0]  res;
reg [7:0]  shv;
reg [7:0]  dpo;
reg        carry;
reg        so;
reg        ov;
reg        fb;
reg        arith;

always @* begin
	cw = cram[fab_in[2:0]];
	m = cfg_reg[`PDT_C_MSB];
	mm = pdt_msk(m);
	opa = pdt_sel(a0_reg, a1_reg, d0_reg, d1_reg, cw[`PDT_W_SRCA]) & mm;
	opb = pdt_sel(a0_reg, a1_reg, d0_reg, d1_reg, cw[`PDT_W_SRCB]) & mm;
	case (cw[`PDT_W_CIN])
	2'h0: cin = 1'b0;
	2'h1: cin = 1'b1;
	2'h2: cin = creg_reg;
	default: cin = chain_ci;
	endcase
	case (cfg_reg[`PDT_C_SIS])
	2'h0: si = fab_in[3];
	2'h1: si = chain_si;
	2'h2: si = sreg_reg;
	default: si = 1'b0;
	endcase
	arith = 1'b1;
	case (cw[`PDT_W_FUNC])
	3'h0: begin bx = 8'h00; cin = 1'b0; end
	3'h1: begin bx = 8'h00; cin = 1'b1; end
	3'h2: begin bx = mm; cin = 1'b0; end
	3'h3: bx = opb;
	3'h4: bx = ~opb & mm;
	default: begin bx = 8'h00; arith = 1'b0; end
	endcase
	sum = {1'b0, opa} + {1'b0, bx} + {8'h00, cin};
	case (cw[`PDT_W_FUNC])
	3'h5: res = opa ^ opb;
	3'h6: res = opa & opb;
	3'h7: res = opa | opb;
	default: res = sum[7:0] & mm;
	endcase
	// Widened index so MSB 7 reaches the ninth sum bit
	carry = arith & sum[{1'b0, m} + 4'h1];
	ov = arith & (opa[m] == bx[m]) & (res[m] != opa[m]);
	fb = res[m] ^ si;
	so = 1'b0;
	if (cw[`PDT_W_CRC]) begin
		so = fb;
		shv = ((res << 1) & mm) ^ (fb ? (poly_reg & mm) : 8'h00);
	end else begin
		case (cw[`PDT_W_SHF])
		2'h1: begin
			shv = ((res << 1) | {7'h00, si}) & mm;
			so = res[m];
		end
		2'h2: begin
			shv = (res >> 1) | (si ? (mm & ~(mm >> 1)) : 8'h00);
			so = res[0];
		end
		2'h3: shv = {res[3:0], res[7:4]} & mm;
		default: shv = res;
		endcase
	end
	dpo = (shv | mask_reg[`PDT_M_OR]) & mm;
end

// ************************************************
// Comparators, conditions and FIFO flags
// ************************************************
reg [7:0]  c0a;
reg [7:0]  c0b;
reg [7:0]  c1a;
reg [7:0]  c1b;
reg        ce0;
reg        ce1;
reg [15:0] cond;

always @* begin
	case (cfg_reg[`PDT_C_CP0])
	2'h0: begin c0a = a0_reg; c0b = d0_reg; end
	2'h1: begin c0a = a1_reg; c0b = d1_reg; end
	2'h2: begin c0a = a0_reg; c0b = a1_reg; end
	default: begin c0a = a1_reg; c0b = d0_reg; end
	endcase
	case (cfg_reg[`PDT_C_CP1])
	2'h0: begin c1a = a1_reg; c1b = d1_reg; end
	2'h1: begin c1a = a0_reg; c1b = d1_reg; end
	2'h2: begin c1a = d0_reg; c1b = d1_reg; end
	default: begin c1a = a0_reg; c1b = d0_reg; end
	endcase
	c0a = c0a & mask_reg[`PDT_M_C0];
	c0b = c0b & mask_reg[`PDT_M_C0];
	c1a = c1a & mask_reg[`PDT_M_C1];
	c1b = c1b & mask_reg[`PDT_M_C1];
	ce0 = (c0a == c0b) & (~cfg_reg[`PDT_C_CHN] | chain_ce_in);
	ce1 = (c1a == c1b);
	for (j = 0; j < 2; j = j + 1) begin
		fe[j] = (fcnt_reg[3*j+:3] == 3'h0);
		ff[j] = (fcnt_reg[3*j+:3] == `PDT_FDEPTH);
	end
	cond = {ff[1], fe[1], ff[0], fe[0], so, carry, ov,
		((a1_reg & mm) == mm), ((a0_reg & mm) == mm),
		((a1_reg & mm) == 8'h00), ((a0_reg & mm) == 8'h00),
		(c1a < c1b), ce1, (c0a < c0b), ce0, chain_ce_in};
end

// ************************************************
// Bus strobes and FIFO transfers
// ************************************************
wire       aw_take = s_axi_awvalid & awrdy_reg;
wire       w_take  = s_axi_wvalid & wrdy_reg;
wire       ar_take = s_axi_arvalid & arrdy_reg;
wire       wr_go   = awh_reg & wh_reg & ~bvalid_reg;
wire [1:0] dir     = cfg_reg[`PDT_C_DIR];
wire [1:0] dst_sel = cw[`PDT_W_DST];
wire [31:0] wv     = pdt_merge(pdt_rmux(awq_reg), wdq_reg, wsq_reg);
reg  [1:0] push;
reg  [1:0] pop;
reg  [1:0] bwr;
reg  [1:0] brd;
reg  [2:0] ev;

always @* begin
	bwr[0] = wr_go & (awq_reg == `PDT_O_F0) & wsq_reg[0];
	bwr[1] = wr_go & (awq_reg == `PDT_O_F1) & wsq_reg[0];
	brd[0] = ar_take & (s_axi_araddr == `PDT_O_F0);
	brd[1] = ar_take & (s_axi_araddr == `PDT_O_F1);
	for (k = 0; k < 2; k = k + 1) begin
		if (dir[k]) begin
			push[k] = fab_in[5] & cw[`PDT_W_FST] & ~ff[k];
			pop[k]  = brd[k] & ~fe[k];
		end else begin
			push[k] = bwr[k] & ~ff[k];
			pop[k]  = fab_in[5] & cw[`PDT_W_FLD] & ~fe[k];
		end
	end
	ev[0] = ce0;
	ev[1] = |(bwr & ~dir & ff);
	ev[2] = |(brd & dir & fe);
end

// ************************************************
// Registers, datapath and FIFO storage
// ************************************************
always @(posedge aclk) begin
	if (!aresetn) begin
		ctrl_reg <= 8'h00;
		stkm_reg <= 8'h00;
		stk_reg <= 8'h00;
		cfg_reg <= `PDT_RST_CFG;
		osel_reg <= `PDT_RST_ZERO;
		poly_reg <= 8'h00;
		mask_reg <= `PDT_RST_ZERO;
		a0_reg <= 8'h00;
		a1_reg <= 8'h00;
		d0_reg <= 8'h00;
		d1_reg <= 8'h00;
		creg_reg <= 1'b0;
		sreg_reg <= 1'b0;
		frp_reg <= 4'h0;
		fcnt_reg <= 6'h00;
		ist_reg <= 3'h0;
		imsk_reg <= 3'h0;
		irq_reg <= 1'b0;
		fab_out_reg <= 6'h00;
		chain_co_reg <= 1'b0;
		chain_so_reg <= 1'b0;
		chain_ce_reg <= 1'b0;
	end else begin
		if (fab_in[4]) begin
			if (dst_sel[0])
				a0_reg <= dpo;
			if (dst_sel[1])
				a1_reg <= dpo;
			creg_reg <= carry;
			sreg_reg <= so;
		end
		if (pop[0] & ~dir[0])
			d0_reg <= fmem[{1'b0, frp_reg[1:0]}];
		if (pop[1] & ~dir[1])
			d1_reg <= fmem[{1'b1, frp_reg[3:2]}];
		for (i = 0; i < 2; i = i + 1) begin
			if (push[i])
				fmem[{i[0], frp_reg[2*i+:2] +
					fcnt_reg[3*i+:2]}] <= dir[i] ?
					(i[0] ? a1_reg : a0_reg) : wdq_reg[7:0];
			if (pop[i])
				frp_reg[2*i+:2] <= frp_reg[2*i+:2] + 2'h1;
			fcnt_reg[3*i+:3] <= fcnt_reg[3*i+:3] +
				{2'h0, push[i]} - {2'h0, pop[i]};
		end
		for (i = 0; i < 6; i = i + 1)
			fab_out_reg[i] <= cond[osel_reg[4*i+:4]];
		chain_co_reg <= carry;
		chain_so_reg <= so;
		chain_ce_reg <= ce0;
		// Sticky status: new event wins over read clear
		stk_reg <= (stk_reg & ~((ar_take &&
			s_axi_araddr == `PDT_O_STAT) ? 8'hFF : 8'h00)) |
			(status_in & stkm_reg);
		ist_reg <= (ist_reg & ~((wr_go && awq_reg == `PDT_O_IST &&
			wsq_reg[0]) ? wdq_reg[2:0] : 3'h0)) | ev;
		irq_reg <= |(ist_reg & imsk_reg);
		if (wr_go) begin
			if (awq_reg[7:5] == `PDT_CRAM_HI)
				cram[awq_reg[4:2]] <= wv[15:0];
			case (awq_reg)
			`PDT_O_CTRL: ctrl_reg <= wv[7:0];
			`PDT_O_STKM: stkm_reg <= wv[7:0];
			`PDT_O_CFG:  cfg_reg <= wv;
			`PDT_O_OSEL: osel_reg <= wv;
			`PDT_O_POLY: poly_reg <= wv[7:0];
			`PDT_O_MASK: mask_reg <= wv;
			`PDT_O_REGS: begin
				a0_reg <= wv[7:0];
				a1_reg <= wv[15:8];
				d0_reg <= wv[23:16];
				d1_reg <= wv[31:24];
			end
			`PDT_O_IMSK: imsk_reg <= wv[2:0];
			default: ;
			endcase
		end
	end
end

// ************************************************
// AXI4-Lite handshakes
// ************************************************
always @(posedge aclk) begin
	if (!aresetn) begin
		awrdy_reg <= 1'b0;
		wrdy_reg <= 1'b0;
		awh_reg <= 1'b0;
		wh_reg <= 1'b0;
		awq_reg <= 8'h00;
		wdq_reg <= `PDT_RST_ZERO;
		wsq_reg <= 4'h0;
		bvalid_reg <= 1'b0;
		bresp_reg <= `PDT_RESP_OK;
		arrdy_reg <= 1'b0;
		rvalid_reg <= 1'b0;
		rdata_reg <= `PDT_RST_ZERO;
		rresp_reg <= `PDT_RESP_OK;
	end else begin
		if (aw_take) begin
			awh_reg <= 1'b1;
			awq_reg <= s_axi_awaddr;
			awrdy_reg <= 1'b0;
		end else if (!awh_reg && !bvalid_reg)
			awrdy_reg <= 1'b1;
		if (w_take) begin
			wh_reg <= 1'b1;
			wdq_reg <= s_axi_wdata;
			wsq_reg <= s_axi_wstrb;
			wrdy_reg <= 1'b0;
		end else if (!wh_reg && !bvalid_reg)
			wrdy_reg <= 1'b1;
		if (wr_go) begin
			awh_reg <= 1'b0;
			wh_reg <= 1'b0;
			bvalid_reg <= 1'b1;
			bresp_reg <= pdt_hit(awq_reg) ? `PDT_RESP_OK : `PDT_RESP_ERR;
		end else if (bvalid_reg && s_axi_bready)
			bvalid_reg <= 1'b0;
		if (ar_take) begin
			arrdy_reg <= 1'b0;
			rvalid_reg <= 1'b1;
			rdata_reg <= pdt_rmux(s_axi_araddr);
			rresp_reg <= pdt_hit(s_axi_araddr) ?
				`PDT_RESP_OK : `PDT_RESP_ERR;
		end else if (rvalid_reg && s_axi_rready)
			rvalid_reg <= 1'b0;
		else if (!rvalid_reg)
			arrdy_reg <= 1'b1;
	end
end

// ************************************************
// Outputs
// ************************************************
assign s_axi_awready = awrdy_reg;
assign s_axi_wready  = wrdy_reg;
assign s_axi_bresp   = bresp_reg;
assign s_axi_bvalid  = bvalid_reg;
assign s_axi_arready = arrdy_reg;
assign s_axi_rdata   = rdata_reg;
assign s_axi_rresp   = rresp_reg;
assign s_axi_rvalid  = rvalid_reg;
assign fab_out       = fab_out_reg;
assign ctl_out       = ctrl_reg;
assign chain_co      = chain_co_reg;
assign chain_so      = chain_so_reg;
assign chain_ce_out  = chain_ce_reg;
assign irq           = irq_reg;

endmodule
`default_nettype wire

// ==== pdt_datapath_asserts.sv ====
// Bus and output checker for the tile datapath
`timescale 1ns/1ps
`default_nettype none
module pdt_dp_chk (
	// Clock and reset
	input wire logic	aclk,
	input wire logic	aresetn,
	// Bus
	input wire logic	s_axi_awvalid,
	input wire logic	s_axi_awready,
	input wire logic	s_axi_wready,
	input wire logic [1:0]	s_axi_bresp,
	input wire logic	s_axi_bvalid,
	input wire logic	s_axi_bready,
	input wire logic	s_axi_arvalid,
	input wire logic	s_axi_arready,
	input wire logic [31:0]	s_axi_rdata,
	input wire logic [1:0]	s_axi_rresp,
	input wire logic	s_axi_rvalid,
	input wire logic	s_axi_rready,
	// Fabric and interrupt
	input wire logic [7:0]	ctl_out,
	input wire logic	irq
);
	// ********
	// Properties
	// ********
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready;
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	wr_answer_a: assert property (wr_taken |-> ##[1:3] s_axi_bvalid)
		else $error("write answer missing");
	rd_answer_a: assert property (rd_taken |=> s_axi_rvalid)
		else $error("read answer late");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read answer dropped");
	wr_block_a: assert property (s_axi_bvalid
		|-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during answer");
	rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken during answer");
	err_data_a: assert property (s_axi_rvalid && s_axi_rresp != 2'h0
		|-> s_axi_rdata == 32'h0)
		else $error("error read carries data");
	ctl_write_a: assert property ($changed(ctl_out) |-> $rose(s_axi_bvalid))
		else $error("control changed without write");
	reset_quiet_a: assert property ($rose(aresetn)
		|-> !irq && ctl_out == 8'h00 && !s_axi_bvalid && !s_axi_rvalid)
		else $error("outputs active after reset");
	irq_clear_a: assert property ($fell(irq)
		|-> s_axi_bvalid || $past(s_axi_bvalid, 1))
		else $error("interrupt fell without write");
endmodule
bind pdt_datapath pdt_dp_chk chk_u (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.ctl_out(ctl_out), .irq(irq));
`default_nettype wire

// ==== pdt_fabric_model.sv ====
// Fabric and idle neighbour model facing the tile datapath
`timescale 1ns/1ps
`default_nettype none
module pdt_fabric (
	// Clock
	input wire logic	aclk,
	// Bench commands
	input wire logic [5:0]	word_cmd,
	input wire logic [3:0]	stat_cmd,
	// Tile side
	input wire logic [7:0]	ctl_out,
	output logic [5:0]	fab_in,
	output logic [7:0]	status_in,
	output logic	chain_ci,
	output logic	chain_si,
	output logic	chain_ce_in
);
	// ********
	// Routing
	// ********
	initial begin
		fab_in = 6'h00;
		status_in = 8'h00;
		chain_ci = 1'b0;
		chain_si = 1'b0;
		chain_ce_in = 1'b0;
	end
	// Upper four control bits loop back into the upper four status bits
	always @(posedge aclk) begin
		fab_in <= word_cmd;
		status_in <= {ctl_out[7:4], stat_cmd};
	end
endmodule
`default_nettype wire

// ==== pdt_datapath_test.sv ====
// Self-checking bench for the tile datapath
`timescale 1ns/1ps
`default_nettype none
`include "pdt_defines.vh"
module pdt_datapath_test;
	localparam logic [1:0] OK = `PDT_RESP_OK;
	logic	aclk = 1'b0;
	logic	aresetn = 1'b0;
	logic [7:0]	awaddr = 8'h00;
	logic [7:0]	araddr = 8'h00;
	logic [31:0]	wdata = 32'h0;
	logic	awvalid = 1'b0;
	logic	wvalid = 1'b0;
	logic	bready = 1'b0;
	logic	arvalid = 1'b0;
	logic	rready = 1'b0;
	logic [5:0]	word_cmd = 6'h00;
	logic [3:0]	stat_cmd = 4'h0;
	wire	awready, wready, bvalid, arready, rvalid, irq, ci, si, cei;
	wire [1:0]	bresp, rresp;
	wire [31:0]	rdata;
	wire [5:0]	fab_in, fab_out;
	wire [7:0]	status_in, ctl_out;
	logic [33:0]	rq[$];
	logic [1:0]	bq[$];
	int	n_fail = 0;
	int	checks = 0;
	logic [7:0]	r, a0, a1, d0, d1, sum;
	logic [8:0]	s9;
	logic [15:0]	s16;

	always #25 aclk = ~aclk;
	pdt_datapath dut_u (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .fab_in(fab_in),
		.status_in(status_in), .fab_out(fab_out), .ctl_out(ctl_out),
		.chain_ci(ci), .chain_si(si), .chain_ce_in(cei), .chain_co(),
		.chain_so(), .chain_ce_out(), .irq(irq));
	pdt_fabric fab_u (.aclk(aclk), .word_cmd(word_cmd),
		.stat_cmd(stat_cmd), .ctl_out(ctl_out), .fab_in(fab_in),
		.status_in(status_in), .chain_ci(ci), .chain_si(si),
		.chain_ce_in(cei));

	// ********
	// Checking and closing
	// ********
	task automatic fail(input string m);
		n_fail++;
		$display("[ERR] %0t %s", $time, m);
	endtask
	task automatic cmp_r(input logic [33:0] g, input logic [33:0] e);
		checks++;
		if (g !== e) fail($sformatf("read %h exp %h", g, e));
	endtask
	task automatic cmp_w(input logic [1:0] g, input logic [1:0] e);
		checks++;
		if (g !== e) fail($sformatf("bresp %h exp %h", g, e));
	endtask
	task automatic cmp_o(input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e) fail($sformatf("output %h exp %h", g, e));
	endtask
	task automatic end_of_test;
		if (n_fail == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic timeout;
		fail("timeout");
		end_of_test();
	endtask
	always @(posedge aclk) begin
		if (rvalid && rready) cmp_r({rresp, rdata}, rq.pop_front());
		if (bvalid && bready) cmp_w(bresp, bq.pop_front());
	end

	// ********
	// Bus and fabric drivers
	// ********
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] e);
		int i;
		bq.push_back(e);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) break;
			if (bvalid) bready <= 1'b1;
		end
		bready <= 1'b0;
		if (i == 40) timeout();
	endtask
	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		int i;
		rq.push_back(e);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) break;
			if (rvalid) rready <= 1'b1;
		end
		rready <= 1'b0;
		if (i == 40) timeout();
	endtask
	task automatic run(input logic [5:0] w0, input logic [5:0] w1);
		@(posedge aclk);
		word_cmd <= w0;
		@(posedge aclk);
		word_cmd <= w1;
		@(posedge aclk);
		word_cmd <= 6'h00;
	endtask

	// ********
	// Scenarios
	// ********
	initial begin
		void'($urandom(32'h7385eea0));
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rd(`PDT_O_CFG, {2'h0, `PDT_RST_CFG});
		rd(`PDT_O_CTRL, 34'h0);
		r = $urandom;
		wr(`PDT_O_CTRL, {24'h0, r}, OK);
		cmp_o(ctl_out, r);
		stat_cmd <= 4'h6;
		wr(`PDT_O_STAT, 32'hFF, OK);
		rd(`PDT_O_STAT, {26'h0, r[7:4], 4'h6});
		wr(`PDT_O_STKM, 32'h1, OK);
		stat_cmd <= 4'h1;
		@(posedge aclk);
		stat_cmd <= 4'h0;
		rd(`PDT_O_STAT, {26'h0, r[7:4], 4'h1});
		rd(`PDT_O_STAT, {26'h0, r[7:4], 4'h0});
		rd(8'h38, {`PDT_RESP_ERR, 32'h0});
		wr(8'h38, 32'h0, `PDT_RESP_ERR);
		wr(`PDT_O_CFG, 32'h47, OK);
		wr(`PDT_O_MASK, 32'hFF, OK);
		wr(`PDT_O_REGS, 32'h1AA, OK);
		wr(`PDT_O_IST, 32'h7, OK);
		wr(`PDT_O_OSEL, 32'hD, OK);
		for (int k = 0; k < 4; k++) wr(`PDT_O_F0, k, OK);
		rd(`PDT_O_FST, {30'h0, 4'h6});
		cmp_o({2'h0, fab_out}, 8'h01);
		wr(`PDT_O_F0, 32'h9, OK);
		repeat (2) @(posedge aclk);
		cmp_o({7'h0, irq}, 8'h00);
		rd(`PDT_O_IST, 34'h2);
		wr(`PDT_O_IMSK, 32'h2, OK);
		repeat (2) @(posedge aclk);
		cmp_o({7'h0, irq}, 8'h01);
		wr(`PDT_O_IST, 32'h2, OK);
		repeat (2) @(posedge aclk);
		cmp_o({7'h0, irq}, 8'h00);
		wr(8'h40, 32'h4000, OK);
		run(6'h30, 6'h30);
		run(6'h30, 6'h30);
		rd(`PDT_O_REGS, 34'h0000301AA);
		rd(`PDT_O_FST, 34'h3);
		wr(8'h44, 32'h146B, OK);
		for (int sh = 0; sh < 4; sh++) begin
			{a0, a1, d0, d1} = $urandom;
			wr(8'h40, 32'h0243 | (sh << 7), OK);
			wr(`PDT_O_REGS, {d1, d0, a1, a0}, OK);
			run(6'h10, 6'h11);
			s9 = a0 + d0;
			sum = s9[7:0];
			case (sh)
				1: sum = sum << 1;
				2: sum = sum >> 1;
				3: sum = {sum[3:0], sum[7:4]};
				default: ;
			endcase
			s16 = a1 + d1 + s9[8];
			rd(`PDT_O_REGS, {2'h0, d1, d0, s16[7:0], sum});
		end
		wr(`PDT_O_OSEL, 32'h75, OK);
		wr(`PDT_O_REGS, 32'hFF, OK);
		cmp_o({2'h0, fab_out}, 8'h02);
		wr(`PDT_O_REGS, 32'h0, OK);
		cmp_o({2'h0, fab_out}, 8'h01);
		end_of_test();
	end
endmodule
`default_nettype wire
